// ---- design/dnim_pkg.sv ----
// shared constants and types of the drive network input mapper
package dnim_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int CLK_HZ = 25_000_000;
  localparam int BUS_TMO_MS = 1000;
  localparam logic [31:0] TMO_CYC_DFLT = 32'(CLK_HZ / 1000 * BUS_TMO_MS);

  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] OFS_RUN_CMD = 8'h00;
  localparam logic [7:0] OFS_CTRL_WORD = 8'h04;
  localparam logic [7:0] OFS_FAULT_CLR = 8'h08;
  localparam logic [7:0] OFS_PCT_REF = 8'h0c;
  localparam logic [7:0] OFS_FREQ_REF = 8'h10;
  localparam logic [7:0] OFS_SETPOINT0 = 8'h14;
  localparam logic [7:0] OFS_FEEDBACK0 = 8'h20;
  localparam logic [7:0] OFS_MEM_LAST = 8'h28;
  localparam logic [7:0] OFS_MASK_LO = 8'h2c;
  localparam logic [7:0] OFS_MASK_HI = 8'h30;
  localparam logic [7:0] OFS_AOUT_MAIN = 8'h34;
  localparam logic [7:0] OFS_AOUT_EXP = 8'h38;
  localparam logic [7:0] OFS_CONFIG = 8'h3c;
  localparam logic [7:0] OFS_PRESET = 8'h40;
  localparam logic [7:0] OFS_TIMEOUT = 8'h44;
  localparam logic [7:0] OFS_STATUS = 8'h48;

  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int CFG_FUNC_W = 8;
  localparam int CFG_GPIO_BIT = 16;
  localparam int CFG_CLOSED_BIT = 17;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [31:0] PRESET_RST = 32'h0000_0000;
  localparam int STAT_TMO_BIT = 17;
  localparam int STAT_RUN_BIT = 16;

  // ****************************************
  // switch states and drive control words
  // ****************************************
  localparam logic [7:0] SW_FALSE = 8'h00;
  localparam logic [7:0] SW_TRUE = 8'h01;
  localparam logic [7:0] SW_AUTO = 8'hff;
  localparam logic [15:0] CW_STOP = 16'h043c;
  localparam logic [15:0] CW_RUN = 16'h047c;
  localparam logic [15:0] CW_RST = 16'h043c;
  localparam int CW_RESET_BIT = 7;
  localparam logic [7:0] RUN_VAL_FULL = 8'hc8;
  localparam logic [15:0] RUN_PCT_STEP = 16'h0064;
  localparam logic [15:0] RUN_REF_FULL = 16'h4e20;

  // ****************************************
  // analog outputs and terminals
  // ****************************************
  localparam int AOUT_CH = 2;
  localparam logic [13:0] AOUT_MAX = 14'h2710;
  localparam logic [7:0] AO_FN_0_20 = 8'h8b;
  localparam logic [7:0] AO_FN_4_20 = 8'h8c;
  localparam logic [7:0] AO_FN_0_20_TMO = 8'h8d;
  localparam logic [7:0] AO_FN_4_20_TMO = 8'h8e;
  localparam int NUM_TERM = 9;
  localparam int NUM_SP = 3;
  localparam int MEM_DEPTH = 8;
  localparam int MEM_AW = 3;
  localparam logic [MEM_AW-1:0] MEM_FB0 = 3'h3;

  typedef struct packed {
    logic valid;
    logic is_hz;
    logic [15:0] value;
  } dnim_ref_t;

  typedef struct packed {
    logic bus_ctrl;
    logic range_4_20;
    logic [13:0] level;
  } dnim_aout_t;

  typedef struct packed {
    logic [2:0] opt_relay;
    logic [1:0] control_card_relay;
    logic [1:0] exp_dout;
    logic [1:0] control_card_dout;
  } dnim_term_t;

  typedef enum logic [1:0] {WB_IDLE, WB_FETCH, WB_ANSWER} dnim_wb_t;

endpackage

// ---- design/dnim_wordmem.sv ----
// word store for closed-loop setpoints and bus feedbacks
`timescale 1ns/10ps
module dnim_wordmem
  import dnim_pkg::*;
(
  // clock and reset
  input logic clk,
  input logic srst,
  // write port
  input logic wr_en,
  input logic [MEM_AW-1:0] wr_addr,
  input logic [15:0] wr_data,
  // registered read port
  input logic [MEM_AW-1:0] rd_addr,
  output logic [15:0] rd_data,
  // every stored word, straight from its flop
  output logic [MEM_DEPTH-1:0][15:0] words
);

  logic [MEM_DEPTH-1:0][15:0] mem_r;
  logic [15:0] rd_data_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      mem_r <= '0;
    end else if (wr_en) begin
      mem_r[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rd_data_r <= 16'h0000;
    end else begin
      rd_data_r <= mem_r[rd_addr];
    end
  end

  assign rd_data = rd_data_r;
  assign words = mem_r;

endmodule

// ---- design/dnim_top.sv ----
// drive network input mapper: bus-written input variables to drive commands
// Functional notes
// - run switch false gives 0x043c, true gives 0x047c with 0.5% reference steps
// - switch state 0xff is automatic and invalid; nothing happens for it
// - run switch reference used only while percent and hertz references are zero
// - software may write the 16-bit drive control word directly
// - fault clear true sets control word bit 7, giving 0x04bc
// - percent reference is signed, 0.005% steps, -163.840% to +163.835%
// - closed loop turns the percent reference into the controller setpoint
// - hertz reference, 0.1 Hz steps, is speed open loop, setpoint closed loop
// - three closed-loop setpoints in signed 0.005% units are held
// - three bus feedbacks in the same units are held
// - each discrete output follows its mask bit, one meaning on
// - mask bits 0 to 8 map to card, expansion and option terminals
// - mask bits 9 to 63 drive nothing
// - main analog level 0 to 100% in 0.01% steps, 0-20 or 4-20 mA
// - bus drives an analog output only for function codes 139 to 142
// - codes 139 and 140 hold the level on bus timeout
// - codes 141 and 142 jump to the timeout preset on bus timeout
// - expansion analog output honoured only with the i/o option fitted
//
// The Wishbone register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module dnim_top
  import dnim_pkg::*;
#(
  parameter logic [31:0] TIMEOUT_CYC = TMO_CYC_DFLT
) (
  // clock and reset
  input logic MCLK,
  input logic SRST,
  // wishbone slave
  input logic WB_CYC,
  input logic WB_STB,
  input logic WB_WE,
  input logic [7:0] WB_ADR,
  input logic [3:0] WB_SEL,
  input logic [31:0] WB_DAT_W,
  output logic [31:0] WB_DAT_R,
  output logic WB_ACK,
  // drive control side
  output logic [15:0] DRV_CTRL_WORD,
  output dnim_ref_t SPEED_REF,
  output dnim_ref_t LOOP_SETPOINT,
  output logic [NUM_SP-1:0][15:0] SETPOINTS,
  output logic [NUM_SP-1:0][15:0] FEEDBACKS,
  output logic BUS_TIMEOUT,
  // output terminals
  output dnim_term_t DISCRETE_OUT,
  output dnim_aout_t [AOUT_CH-1:0] ANALOG_OUT
);

  // ****************************************
  // bus slave
  // ****************************************
  dnim_wb_t wb_st_r;
  logic ack_r;
  logic [31:0] dat_r;
  logic req;
  logic wr_fire;
  logic [7:0] ofs;
  logic [31:0] rd_mux;
  logic [31:0] wdat;
  logic mem_hit;
  logic [MEM_AW-1:0] mem_idx;
  logic [15:0] mem_rd;
  logic [MEM_DEPTH-1:0][15:0] mem_words;

  logic [7:0] run_state_r;
  logic [7:0] run_val_r;
  logic [7:0] flt_state_r;
  logic run_on_r;
  logic [15:0] run_ref_r;
  logic [15:0] cw_r;
  logic [15:0] pct_r;
  logic [15:0] hz_r;
  logic [63:0] mask_r;
  logic [31:0] cfg_r;
  logic [31:0] preset_r;
  logic [31:0] tmo_cyc_r;
  logic [31:0] tmo_cnt_r;
  logic tmo_r;
  logic tmo_set;
  logic wr_in;
  dnim_ref_t speed_r;
  dnim_ref_t setp_r;
  dnim_ref_t ref_sel;
  logic [NUM_TERM-1:0] term_bits;
  logic [AOUT_CH-1:0] fitted;
  logic [AOUT_CH-1:0] lvl_wr;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [13:0] clamp(input logic [15:0] v);
    return (v > 16'(AOUT_MAX)) ? AOUT_MAX : v[13:0];
  endfunction

  assign req = WB_CYC && WB_STB;
  assign ofs = {WB_ADR[7:2], 2'b00};
  // writes land at the edge where the master sees ack, never earlier
  assign wr_fire = req && WB_WE && (wb_st_r == WB_ANSWER);
  assign mem_hit = (ofs >= OFS_SETPOINT0) && (ofs <= OFS_MEM_LAST);
  assign mem_idx = MEM_AW'((ofs - OFS_SETPOINT0) >> 2);
  // sub-word writes merge with the value that a read would return
  assign wdat = merge(rd_mux, WB_DAT_W, WB_SEL);

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (mem_hit) begin
      rd_mux = {16'h0000, mem_rd};
    end else begin
      case (ofs)
        OFS_RUN_CMD: rd_mux = {16'h0000, run_state_r, run_val_r};
        OFS_CTRL_WORD: rd_mux = {16'h0000, cw_r};
        OFS_FAULT_CLR: rd_mux = {16'h0000, flt_state_r, 8'h00};
        OFS_PCT_REF: rd_mux = {16'h0000, pct_r};
        OFS_FREQ_REF: rd_mux = {16'h0000, hz_r};
        OFS_MASK_LO: rd_mux = mask_r[31:0];
        OFS_MASK_HI: rd_mux = mask_r[63:32];
        OFS_AOUT_MAIN: rd_mux = {18'h00000, ANALOG_OUT[0].level};
        OFS_AOUT_EXP: rd_mux = {18'h00000, ANALOG_OUT[1].level};
        OFS_CONFIG: rd_mux = cfg_r;
        OFS_PRESET: rd_mux = preset_r;
        OFS_TIMEOUT: rd_mux = tmo_cyc_r;
        OFS_STATUS: rd_mux = {14'h0000, tmo_r, run_on_r, cw_r};
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // one wait state lets the word store present its registered read data
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      wb_st_r <= WB_IDLE;
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      unique case (wb_st_r)
        WB_IDLE: begin
          if (req) begin
            wb_st_r <= WB_FETCH;
          end
        end
        WB_FETCH: begin
          wb_st_r <= WB_ANSWER;
          ack_r <= 1'b1;
          dat_r <= rd_mux;
        end
        WB_ANSWER: begin
          wb_st_r <= WB_IDLE;
          ack_r <= 1'b0;
        end
      endcase
    end
  end

  dnim_wordmem u_mem (
    .clk(MCLK),
    .srst(SRST),
    .wr_en(wr_fire && mem_hit),
    .wr_addr(mem_idx),
    .wr_data(wdat[15:0]),
    .rd_addr(mem_idx),
    .rd_data(mem_rd),
    .words(mem_words)
  );

  // ****************************************
  // switch inputs and control word
  // ****************************************
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      run_state_r <= SW_AUTO;
      run_val_r <= 8'h00;
      flt_state_r <= SW_AUTO;
      run_on_r <= 1'b0;
      run_ref_r <= 16'h0000;
    end else if (wr_fire && ofs == OFS_RUN_CMD) begin
      run_state_r <= wdat[15:8];
      run_val_r <= wdat[7:0];
      if (wdat[15:8] == SW_FALSE) begin
        run_on_r <= 1'b0;
        run_ref_r <= 16'h0000;
      end else if (wdat[15:8] == SW_TRUE) begin
        run_on_r <= 1'b1;
        if (wdat[7:0] > RUN_VAL_FULL) begin
          run_ref_r <= RUN_REF_FULL;
        end else begin
          run_ref_r <= 16'(16'(wdat[7:0]) * RUN_PCT_STEP);
        end
      end
    end else if (wr_fire && ofs == OFS_FAULT_CLR) begin
      flt_state_r <= wdat[15:8];
    end
  end

  // other switch states, 0xff among them, leave the word untouched
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      cw_r <= CW_RST;
    end else if (wr_fire && ofs == OFS_CTRL_WORD) begin
      cw_r <= wdat[15:0];
    end else if (wr_fire && ofs == OFS_RUN_CMD && wdat[15:8] == SW_FALSE) begin
      cw_r <= CW_STOP;
    end else if (wr_fire && ofs == OFS_RUN_CMD && wdat[15:8] == SW_TRUE) begin
      cw_r <= CW_RUN;
    end else if (wr_fire && ofs == OFS_FAULT_CLR && wdat[15:8] == SW_TRUE) begin
      cw_r[CW_RESET_BIT] <= 1'b1;
    end else if (wr_fire && ofs == OFS_FAULT_CLR && wdat[15:8] == SW_FALSE) begin
      cw_r[CW_RESET_BIT] <= 1'b0;
    end
  end

  // ****************************************
  // references
  // ****************************************
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      pct_r <= 16'h0000;
      hz_r <= 16'h0000;
    end else if (wr_fire && ofs == OFS_PCT_REF) begin
      pct_r <= wdat[15:0];
    end else if (wr_fire && ofs == OFS_FREQ_REF) begin
      hz_r <= wdat[15:0];
    end
  end

  // percent wins over hertz when both are set
  always_comb begin
    if (pct_r != 16'h0000) begin
      ref_sel = '{valid: 1'b1, is_hz: 1'b0, value: pct_r};
    end else if (hz_r != 16'h0000) begin
      ref_sel = '{valid: 1'b1, is_hz: 1'b1, value: hz_r};
    end else begin
      ref_sel = '{valid: run_on_r, is_hz: 1'b0, value: run_ref_r};
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      speed_r <= '0;
      setp_r <= '0;
    end else if (cfg_r[CFG_CLOSED_BIT]) begin
      speed_r <= '0;
      setp_r <= ref_sel;
    end else begin
      speed_r <= ref_sel;
      setp_r <= '0;
    end
  end

  // ****************************************
  // configuration and discrete outputs
  // ****************************************
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      cfg_r <= CFG_RST;
      preset_r <= PRESET_RST;
      tmo_cyc_r <= TIMEOUT_CYC;
      mask_r <= '0;
    end else if (wr_fire) begin
      if (ofs == OFS_CONFIG) cfg_r <= wdat;
      if (ofs == OFS_PRESET) preset_r <= wdat;
      if (ofs == OFS_TIMEOUT) tmo_cyc_r <= wdat;
      if (ofs == OFS_MASK_LO) mask_r[31:0] <= wdat;
      if (ofs == OFS_MASK_HI) mask_r[63:32] <= wdat;
    end
  end

  // upper mask bits are stored for readback only
  for (genvar t = 0; t < NUM_TERM; t++) begin : g_term
    logic q_r;
    always_ff @(posedge MCLK) begin
      if (SRST) begin
        q_r <= 1'b0;
      end else begin
        q_r <= mask_r[t];
      end
    end
    assign term_bits[t] = q_r;
  end

  // ****************************************
  // bus timeout
  // ****************************************
  assign wr_in = wr_fire && (ofs <= OFS_AOUT_EXP);
  // a zero interval switches supervision off
  assign tmo_set = !tmo_r && !wr_in && (tmo_cyc_r != 32'h0000_0000) &&
                   (tmo_cnt_r == 32'(tmo_cyc_r - 32'h0000_0001));

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      tmo_cnt_r <= 32'h0000_0000;
      tmo_r <= 1'b0;
    end else if (wr_in) begin
      tmo_cnt_r <= 32'h0000_0000;
      tmo_r <= 1'b0;
    end else if (tmo_set) begin
      tmo_r <= 1'b1;
    end else if (!tmo_r) begin
      tmo_cnt_r <= 32'(tmo_cnt_r + 32'h0000_0001);
    end
  end

  // ****************************************
  // analog outputs
  // ****************************************
  assign fitted = {cfg_r[CFG_GPIO_BIT], 1'b1};
  assign lvl_wr = {wr_fire && ofs == OFS_AOUT_EXP, wr_fire && ofs == OFS_AOUT_MAIN};

  for (genvar c = 0; c < AOUT_CH; c++) begin : g_aout
    logic [7:0] fn;
    logic bus_md;
    logic use_preset;
    dnim_aout_t ao_r;
    assign fn = cfg_r[c*CFG_FUNC_W +: CFG_FUNC_W];
    assign bus_md = fitted[c] && (fn >= AO_FN_0_20) && (fn <= AO_FN_4_20_TMO);
    assign use_preset = (fn == AO_FN_0_20_TMO) || (fn == AO_FN_4_20_TMO);
    // leaving bus control releases the terminal to its local function
    always_ff @(posedge MCLK) begin
      if (SRST) begin
        ao_r <= '0;
      end else if (!bus_md) begin
        ao_r <= '0;
      end else begin
        ao_r.bus_ctrl <= 1'b1;
        ao_r.range_4_20 <= (fn == AO_FN_4_20) || (fn == AO_FN_4_20_TMO);
        if (lvl_wr[c]) begin
          ao_r.level <= clamp(wdat[15:0]);
        end else if (tmo_set && use_preset) begin
          ao_r.level <= clamp(preset_r[c*16 +: 16]);
        end
      end
    end
    assign ANALOG_OUT[c] = ao_r;
  end

  // ****************************************
  // outputs
  // ****************************************
  assign WB_ACK = ack_r;
  assign WB_DAT_R = dat_r;
  assign DRV_CTRL_WORD = cw_r;
  assign SPEED_REF = speed_r;
  assign LOOP_SETPOINT = setp_r;
  assign SETPOINTS = mem_words[NUM_SP-1:0];
  assign FEEDBACKS = mem_words[MEM_FB0 +: NUM_SP];
  assign BUS_TIMEOUT = tmo_r;
  assign DISCRETE_OUT = dnim_term_t'(term_bits);

  // ****************************************
  // assertions
  // ****************************************
  logic wr_run;
  logic wr_flt;
  assign wr_run = wr_fire && ofs == OFS_RUN_CMD;
  assign wr_flt = wr_fire && ofs == OFS_FAULT_CLR;

  property p_stop_word;
    @(posedge MCLK) disable iff (SRST)
    wr_run && wdat[15:8] == SW_FALSE && pct_r == 16'h0000 && hz_r == 16'h0000 |=>
      DRV_CTRL_WORD == CW_STOP ##1 !SPEED_REF.valid;
  endproperty
  a_stop_word: assert property (p_stop_word) else $error("stop word not issued");

  property p_run_full;
    @(posedge MCLK) disable iff (SRST)
    wr_run && wdat[15:8] == SW_TRUE && wdat[7:0] > RUN_VAL_FULL |=>
      DRV_CTRL_WORD == CW_RUN && run_ref_r == RUN_REF_FULL;
  endproperty
  a_run_full: assert property (p_run_full) else $error("run at full not issued");

  property p_auto_none;
    @(posedge MCLK) disable iff (SRST)
    (wr_run || wr_flt) && wdat[15:8] == SW_AUTO |=> $stable(DRV_CTRL_WORD) && $stable(run_on_r);
  endproperty
  a_auto_none: assert property (p_auto_none) else $error("auto state acted on");

  property p_ref_gate;
    @(posedge MCLK) disable iff (SRST)
    pct_r != 16'h0000 && !cfg_r[CFG_CLOSED_BIT] |=> SPEED_REF.value == $past(pct_r);
  endproperty
  a_ref_gate: assert property (p_ref_gate) else $error("run reference overrode percent");

  property p_cw_write;
    @(posedge MCLK) disable iff (SRST)
    wr_fire && ofs == OFS_CTRL_WORD |=> DRV_CTRL_WORD == $past(wdat[15:0]);
  endproperty
  a_cw_write: assert property (p_cw_write) else $error("control word not taken");

  property p_fault_bit;
    @(posedge MCLK) disable iff (SRST)
    wr_flt && wdat[15:8] == SW_TRUE |=> DRV_CTRL_WORD[CW_RESET_BIT];
  endproperty
  a_fault_bit: assert property (p_fault_bit) else $error("fault reset bit not set");

  property p_closed_loop;
    @(posedge MCLK) disable iff (SRST)
    cfg_r[CFG_CLOSED_BIT] && pct_r != 16'h0000 |=>
      !SPEED_REF.valid && LOOP_SETPOINT.valid && LOOP_SETPOINT.value == $past(pct_r);
  endproperty
  a_closed_loop: assert property (p_closed_loop) else $error("setpoint not routed");

  property p_mask_map;
    @(posedge MCLK) disable iff (SRST)
    1'b1 |=> DISCRETE_OUT == $past(mask_r[NUM_TERM-1:0]);
  endproperty
  a_mask_map: assert property (p_mask_map) else $error("terminals differ from mask");

  property p_no_bus;
    @(posedge MCLK) disable iff (SRST)
    !g_aout[0].bus_md |=> !ANALOG_OUT[0].bus_ctrl && ANALOG_OUT[0].level == 14'h0000;
  endproperty
  a_no_bus: assert property (p_no_bus) else $error("bus value used outside bus modes");

  property p_hold;
    @(posedge MCLK) disable iff (SRST)
    tmo_set && g_aout[0].bus_md && !g_aout[0].use_preset && !lvl_wr[0] |=>
      ANALOG_OUT[0].level == $past(ANALOG_OUT[0].level);
  endproperty
  a_hold: assert property (p_hold) else $error("level moved on timeout");

  property p_preset;
    @(posedge MCLK) disable iff (SRST)
    tmo_set && g_aout[0].bus_md && g_aout[0].use_preset |=>
      ANALOG_OUT[0].level == clamp($past(preset_r[15:0]));
  endproperty
  a_preset: assert property (p_preset) else $error("preset not applied");

  property p_gpio;
    @(posedge MCLK) disable iff (SRST)
    !cfg_r[CFG_GPIO_BIT] |=> !ANALOG_OUT[1].bus_ctrl;
  endproperty
  a_gpio: assert property (p_gpio) else $error("expansion output without option");

  property p_timeout;
    @(posedge MCLK) disable iff (SRST)
    tmo_set |=> BUS_TIMEOUT ##1 BUS_TIMEOUT || $past(wr_in);
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout flag not raised");

  c_run: cover property (@(posedge MCLK) disable iff (SRST) wr_run ##1 SPEED_REF.valid);
  c_fault: cover property (@(posedge MCLK) disable iff (SRST) wr_flt ##1 DRV_CTRL_WORD[7]);
  c_preset: cover property (@(posedge MCLK) disable iff (SRST) tmo_set && g_aout[0].use_preset);

endmodule

// ---- verif/dnim_node.sv ----
// network node model: wishbone master that writes the input variables
`timescale 1ns/10ps
module dnim_node
  import dnim_pkg::*;
(
  // clock
  input logic MCLK,
  // wishbone master side
  output logic WB_CYC,
  output logic WB_STB,
  output logic WB_WE,
  output logic [7:0] WB_ADR,
  output logic [3:0] WB_SEL,
  output logic [31:0] WB_DAT_W,
  input logic [31:0] WB_DAT_R,
  input logic WB_ACK
);
  // ****************************************
  // bus cycle
  // ****************************************
  initial begin
    WB_CYC = 1'b0;
    WB_STB = 1'b0;
    WB_WE = 1'b0;
    WB_ADR = 8'h00;
    WB_SEL = 4'hf;
    WB_DAT_W = 32'h0000_0000;
  end

  // request held until ack is sampled; only the bench timeout ends a hang
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                      output logic [31:0] rd);
    @(posedge MCLK);
    WB_CYC <= 1'b1;
    WB_STB <= 1'b1;
    WB_WE <= we;
    WB_SEL <= 4'hf;
    WB_ADR <= adr;
    WB_DAT_W <= dat;
    @(posedge MCLK);
    while (WB_ACK !== 1'b1) @(posedge MCLK);
    rd = WB_DAT_R;
    WB_CYC <= 1'b0;
    WB_STB <= 1'b0;
    // released data must not keep showing the last value
    WB_DAT_W <= ~dat;
  endtask
endmodule

// ---- verif/tb.sv ----
// self-checking bench of the drive network input mapper
`timescale 1ns/10ps
module tb
  import dnim_pkg::*;
;
  logic MCLK = 1'b0;
  logic SRST = 1'b1;
  logic cyc_w, stb_w, we_w, ack_w, tmo_w;
  logic [7:0] adr_w;
  logic [3:0] sel_w;
  logic [31:0] dw_w, dr_w, rd, r, lf;
  logic [15:0] cw_w, v;
  logic [NUM_SP-1:0][15:0] sp_w, fb_w;
  dnim_ref_t spd_w, loop_w;
  dnim_term_t dout_w;
  dnim_aout_t [AOUT_CH-1:0] ao_w;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;

  always #20 MCLK = ~MCLK;

  dnim_node i_dnim_node (.MCLK(MCLK), .WB_CYC(cyc_w), .WB_STB(stb_w), .WB_WE(we_w),
    .WB_ADR(adr_w), .WB_SEL(sel_w), .WB_DAT_W(dw_w), .WB_DAT_R(dr_w), .WB_ACK(ack_w));

  dnim_top #(.TIMEOUT_CYC(32'd200)) i_dnim_top (.MCLK(MCLK), .SRST(SRST), .WB_CYC(cyc_w),
    .WB_STB(stb_w), .WB_WE(we_w), .WB_ADR(adr_w), .WB_SEL(sel_w), .WB_DAT_W(dw_w),
    .WB_DAT_R(dr_w), .WB_ACK(ack_w), .DRV_CTRL_WORD(cw_w), .SPEED_REF(spd_w),
    .LOOP_SETPOINT(loop_w), .SETPOINTS(sp_w), .FEEDBACKS(fb_w), .BUS_TIMEOUT(tmo_w),
    .DISCRETE_OUT(dout_w), .ANALOG_OUT(ao_w));

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h0040_0007 : 32'h0);
  endfunction

  function automatic logic [15:0] run_ref(input logic [7:0] val);
    return (val > RUN_VAL_FULL) ? RUN_REF_FULL : 16'(val) * RUN_PCT_STEP;
  endfunction

  // analog levels saturate at full scale
  function automatic logic [15:0] lvl(input logic [15:0] x);
    return (x > 16'(AOUT_MAX)) ? 16'(AOUT_MAX) : x;
  endfunction

  task automatic nxt();
    lf = lfsr(lf);
    r = lf;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_dnim_node.xfer(1'b1, a, d, rd);
    repeat (2) @(posedge MCLK);
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic stop_test();
    if (mismatches == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  always @(posedge MCLK) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      stop_test();
    end
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    lf = 32'he30f42e8;
    repeat (5) @(posedge MCLK);
    SRST <= 1'b0;
    chk("cw reset", CW_RST, cw_w);
    nxt();
    wr(OFS_CTRL_WORD, r);
    chk("cw direct", r[15:0], cw_w);
    for (int i = 0; i < 16; i++) begin
      nxt();
      if (i < 5) r[7:0] = (i == 0) ? 8'h00 : (i == 1) ? 8'h01 : (i == 2) ? 8'hc8 : 8'hc9 + i;
      wr(OFS_RUN_CMD, {16'h0, SW_TRUE, r[7:0]});
      chk("cw run", CW_RUN, cw_w);
      chk("run ref", {14'h0, 2'b10, run_ref(r[7:0])}, 32'(spd_w));
    end
    wr(OFS_RUN_CMD, {16'h0, SW_AUTO, 8'h10});
    chk("cw auto", CW_RUN, cw_w);
    wr(OFS_RUN_CMD, {16'h0, SW_FALSE, 8'h10});
    chk("cw stop", CW_STOP, cw_w);
    wr(OFS_FAULT_CLR, {16'h0, SW_TRUE, 8'h00});
    chk("cw fault", 32'h04bc, cw_w);
    wr(OFS_FAULT_CLR, {16'h0, SW_AUTO, 8'h00});
    chk("cw fault auto", 32'h04bc, cw_w);
    wr(OFS_FAULT_CLR, {16'h0, SW_FALSE, 8'h00});
    chk("cw no fault", CW_STOP, cw_w);
    wr(OFS_RUN_CMD, {16'h0, SW_TRUE, 8'h05});
    nxt();
    r[15] = 1'b1;
    wr(OFS_PCT_REF, r[15:0]);
    chk("pct ref", {2'b10, r[15:0]}, 32'(spd_w));
    i_dnim_node.xfer(1'b0, OFS_PCT_REF, 32'h0, rd);
    chk("pct readback", {16'h0, r[15:0]}, rd);
    wr(OFS_CONFIG, 32'h1 << CFG_CLOSED_BIT);
    chk("loop sp pct", {2'b10, r[15:0]}, 32'(loop_w));
    chk("speed closed", 32'h0, 32'(spd_w));
    wr(OFS_PCT_REF, 32'h0);
    wr(OFS_FREQ_REF, 32'hffff);
    chk("loop sp hz", {2'b11, 16'hffff}, 32'(loop_w));
    wr(OFS_CONFIG, 32'h0);
    chk("speed hz", {2'b11, 16'hffff}, 32'(spd_w));
    for (int k = 0; k < NUM_SP; k++) begin
      nxt();
      wr(OFS_SETPOINT0 + 8'(4 * k), r[15:0]);
      wr(OFS_FEEDBACK0 + 8'(4 * k), r[31:16]);
      chk("setpoint", r[15:0], sp_w[k]);
      chk("feedback", r[31:16], fb_w[k]);
    end
    nxt();
    wr(OFS_MASK_LO, r);
    wr(OFS_MASK_HI, ~r);
    chk("discrete", r[8:0], 32'(dout_w));
    i_dnim_node.xfer(1'b0, 8'h4c, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    for (int c = 139; c <= 142; c++) begin
      nxt();
      wr(OFS_CONFIG, 32'((1 << CFG_GPIO_BIT) | (c << 8) | c));
      wr(OFS_PRESET, {2'b0, r[29:16], 2'b0, r[13:0]});
      v = 16'(r[31:18] % 14'h2710);
      wr(OFS_AOUT_MAIN, v);
      wr(OFS_AOUT_EXP, v);
      chk("aout bus", {1'b1, c[0] == 1'b0, v[13:0]}, 32'(ao_w[0]));
      chk("aout exp", {1'b1, c[0] == 1'b0, v[13:0]}, 32'(ao_w[1]));
      repeat (260) @(posedge MCLK);
      chk("timeout", 32'h1, 32'(tmo_w));
      if (c > 140) v = lvl({2'b0, r[13:0]});
      chk("aout tmo", {1'b1, c[0] == 1'b0, v[13:0]}, 32'(ao_w[0]));
      if (c > 140) v = lvl({2'b0, r[29:16]});
      chk("aout exp tmo", {1'b1, c[0] == 1'b0, v[13:0]}, 32'(ao_w[1]));
    end
    wr(OFS_CONFIG, 32'h8b00);
    wr(OFS_AOUT_MAIN, 32'h64);
    chk("aout off", 32'h0, 32'(ao_w[0]));
    chk("aout no opt", 32'h0, 32'(ao_w[1]));
    chk("timeout clr", 32'h0, 32'(tmo_w));
    stop_test();
  end
endmodule
